/* File: verilog/tbx_pkg.sv */
package tbx_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [3:0] IDX_CTRL_PRIMARY = 4'h0;
  localparam logic [3:0] IDX_CTRL_MODE    = 4'h1;
  localparam logic [3:0] IDX_EVENT_CTRL   = 4'h4;
  localparam logic [3:0] IDX_SRC_ENABLES  = 4'h5;
  localparam logic [3:0] IDX_PENDING      = 4'h6;
  localparam logic [3:0] IDX_RUN_STATE    = 4'h7;
  localparam logic [3:0] IDX_DEBUG_HALT   = 4'h8;
  localparam logic [3:0] IDX_STAGING      = 4'h9;
  localparam logic [3:0] IDX_COUNTER      = 4'ha;
  localparam logic [3:0] IDX_COMPARE      = 4'hc;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ENABLE_BIT    = 0;
  localparam int TICK_SEL_LSB  = 1;
  localparam int TICK_SEL_MSB  = 3;
  localparam int KEEP_STDBY    = 6;
  localparam int MODE_LSB      = 0;
  localparam int MODE_MSB      = 2;
  localparam int ASYNC_BIT     = 6;
  localparam int SNAP_IN_EN    = 0;
  localparam int EDGE_BIT      = 4;
  localparam int SNAP_FLAG     = 0;
  localparam int WRAP_FLAG     = 1;
  localparam int RUN_BIT       = 0;
  localparam int DBG_KEEP_BIT  = 0;

  // ---------------------------------------------------------------
  // values
  // ---------------------------------------------------------------
  localparam logic [7:0]  RESET_BYTE   = 8'h00;
  localparam logic [15:0] RESET_WORD   = 16'h0000;
  localparam logic [15:0] COUNT_MAX    = 16'hffff;
  localparam logic [1:0]  FLAG_MASK    = 2'h3;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    TICK_DIV1  = 3'h0,
    TICK_DIV2  = 3'h1,
    TICK_TMRA0 = 3'h2,
    TICK_TMRA1 = 3'h3,
    TICK_EVENT = 3'h7
  } tbx_tick_t;

  typedef enum logic [2:0] {
    MODE_PERIODIC = 3'h0,
    MODE_TIMEOUT  = 3'h1,
    MODE_CAPTURE  = 3'h2,
    MODE_FREQ     = 3'h3,
    MODE_PWIDTH   = 3'h4,
    MODE_FREQ_PW  = 3'h5,
    MODE_SINGLE   = 3'h6,
    MODE_PWM8     = 3'h7
  } tbx_mode_t;
endpackage

/* File: verilog/tbx_timer_evt.sv */
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
module tbx_timer_evt (
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // axi4-lite write
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // event inputs and other timer ticks
  input  wire logic        snapshot_evt_in,
  input  wire logic        count_evt_in,
  input  wire logic        tmra0_tick,
  input  wire logic        tmra1_tick,
  // power and debug state
  input  wire logic        sleep_standby,
  input  wire logic        sleep_powerdown,
  input  wire logic        debug_halt,
  // event and interrupt outputs
  output logic             snapshot_event,
  output logic             wrap_event,
  output logic             irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]  control_primary;
  logic [7:0]  control_mode;
  logic [7:0]  event_input_control;
  logic [7:0]  source_enables;
  logic [1:0]  pending_flags;
  logic [7:0]  debug_halt_control;
  logic [7:0]  byte_staging;
  logic [15:0] counter_value;
  logic [15:0] compare_capture_value;
  logic        running;
  logic        div2;
  logic        cnt_smp;
  logic        cnt_prev;
  logic        snap_smp;
  logic        snap_prev;
  logic        async_catch;
  logic        async_s1;
  logic        async_s2;
  logic        async_prev;
  logic        async_clr;
  logic [3:0]  rd_idx;

  logic [15:0] next_cnt;
  logic [15:0] next_compare_capture_value;
  logic        next_run;
  logic        snap_set;
  logic        wrap_set;
  logic        tick;
  logic        active;
  logic        pos_e;
  logic        neg_e;
  logic        sel_e;
  logic        oth_e;
  logic        async_e;
  logic        trig;
  logic        wr_fire;
  logic        rd_fire;
  logic [3:0]  wr_idx;
  logic [1:0]  flag_clr;
  logic        cnt_wr;
  logic        compare_capture_value_wr;
  logic [31:0] rd_word;

  wire [2:0] tick_sel = control_primary[tbx_pkg::TICK_SEL_MSB:
                                        tbx_pkg::TICK_SEL_LSB];
  wire [2:0] mode     = control_mode[tbx_pkg::MODE_MSB:
                                     tbx_pkg::MODE_LSB];
  wire edge_inv = event_input_control[tbx_pkg::EDGE_BIT];
  wire snap_go  = event_input_control[tbx_pkg::SNAP_IN_EN];
  wire async_on = control_mode[tbx_pkg::ASYNC_BIT] &&
                  mode == tbx_pkg::MODE_SINGLE;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic mapped(input logic [3:0] idx);
    case (idx)
      tbx_pkg::IDX_CTRL_PRIMARY, tbx_pkg::IDX_CTRL_MODE,
      tbx_pkg::IDX_EVENT_CTRL, tbx_pkg::IDX_SRC_ENABLES,
      tbx_pkg::IDX_PENDING, tbx_pkg::IDX_RUN_STATE,
      tbx_pkg::IDX_DEBUG_HALT, tbx_pkg::IDX_STAGING,
      tbx_pkg::IDX_COUNTER, tbx_pkg::IDX_COMPARE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // ---------------------------------------------------------------
  // bus slave: write and read together in one beat each
  // ---------------------------------------------------------------
  assign wr_idx  = s_axi_awaddr[5:2];
  assign wr_fire = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  assign rd_fire = s_axi_arready && s_axi_arvalid;
  assign cnt_wr  = wr_fire && wr_idx == tbx_pkg::IDX_COUNTER;
  assign compare_capture_value_wr = wr_fire && wr_idx == tbx_pkg::IDX_COMPARE;
  assign flag_clr = (wr_fire && wr_idx == tbx_pkg::IDX_PENDING &&
                     s_axi_wstrb[0]) ? s_axi_wdata[1:0] : 2'h0;

  // write channel: ready is raised only once both halves are offered
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= tbx_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wr_fire) begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= mapped(wr_idx) ? tbx_pkg::RESP_OKAY
                                        : tbx_pkg::RESP_SLVERR;
      end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
                   !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= tbx_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_fire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= mapped(rd_idx) ? tbx_pkg::RESP_OKAY
                                        : tbx_pkg::RESP_SLVERR;
      end else if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // read mux; unmapped words read as zero
  assign rd_idx = s_axi_araddr[5:2];
  always_comb begin
    rd_word = 32'h0000_0000;
    case (rd_idx)
      tbx_pkg::IDX_CTRL_PRIMARY: rd_word[7:0] = control_primary;
      tbx_pkg::IDX_CTRL_MODE:    rd_word[7:0] = control_mode;
      tbx_pkg::IDX_EVENT_CTRL:   rd_word[7:0] = event_input_control;
      tbx_pkg::IDX_SRC_ENABLES:  rd_word[7:0] = source_enables;
      tbx_pkg::IDX_PENDING:      rd_word[1:0] = pending_flags;
      tbx_pkg::IDX_RUN_STATE:    rd_word[0]   = running;
      tbx_pkg::IDX_DEBUG_HALT:   rd_word[7:0] = debug_halt_control;
      tbx_pkg::IDX_STAGING:      rd_word[7:0] = byte_staging;
      tbx_pkg::IDX_COUNTER:      rd_word[15:0] = counter_value;
      tbx_pkg::IDX_COMPARE:      rd_word[15:0] = compare_capture_value;
      default:                   rd_word = 32'h0000_0000;
    endcase
  end

  // software-owned control bytes
  always_ff @(posedge clk) begin
    if (rst) begin
      control_primary     <= tbx_pkg::RESET_BYTE;
      control_mode        <= tbx_pkg::RESET_BYTE;
      event_input_control <= tbx_pkg::RESET_BYTE;
      source_enables      <= tbx_pkg::RESET_BYTE;
      debug_halt_control  <= tbx_pkg::RESET_BYTE;
      byte_staging        <= tbx_pkg::RESET_BYTE;
    end else if (ce && wr_fire && s_axi_wstrb[0]) begin
      case (wr_idx)
        tbx_pkg::IDX_CTRL_PRIMARY: control_primary <= s_axi_wdata[7:0];
        tbx_pkg::IDX_CTRL_MODE:    control_mode <= s_axi_wdata[7:0];
        tbx_pkg::IDX_EVENT_CTRL:   event_input_control <= s_axi_wdata[7:0];
        tbx_pkg::IDX_SRC_ENABLES:  source_enables <= s_axi_wdata[7:0];
        tbx_pkg::IDX_DEBUG_HALT:   debug_halt_control <= s_axi_wdata[7:0];
        tbx_pkg::IDX_STAGING:      byte_staging <= s_axi_wdata[7:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // event inputs
  // ---------------------------------------------------------------
  // event network shares the clock: one sample plus one history bit
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_smp   <= 1'b0;
      cnt_prev  <= 1'b0;
      snap_smp  <= 1'b0;
      snap_prev <= 1'b0;
    end else if (ce) begin
      cnt_smp   <= count_evt_in;
      cnt_prev  <= cnt_smp;
      snap_smp  <= snapshot_evt_in;
      snap_prev <= snap_smp;
    end
  end
  assign pos_e = snap_smp && !snap_prev;
  assign neg_e = !snap_smp && snap_prev;
  assign sel_e = edge_inv ? neg_e : pos_e;
  assign oth_e = edge_inv ? pos_e : neg_e;

  // async catch: clocked by the event itself so sub-cycle pulses stick
  always_ff @(posedge snapshot_evt_in or posedge async_clr) begin
    if (async_clr) begin
      async_catch <= 1'b0;
    end else begin
      async_catch <= 1'b1;
    end
  end

  // bring the caught edge over; clear it once seen (held clear in reset)
  always_ff @(posedge clk) begin
    if (rst) begin
      async_s1   <= 1'b0;
      async_s2   <= 1'b0;
      async_prev <= 1'b0;
      async_clr  <= 1'b1;
    end else if (ce) begin
      async_s1   <= async_catch;
      async_s2   <= async_s1;
      async_prev <= async_s2;
      async_clr  <= async_s2 || !async_on;
    end
  end
  assign async_e = async_s2 && !async_prev;

  // ---------------------------------------------------------------
  // tick source and halt conditions
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      div2 <= 1'b0;
    end else if (ce) begin
      div2 <= !div2;
    end
  end

  always_comb begin
    case (tick_sel)
      tbx_pkg::TICK_DIV1:  tick = 1'b1;
      tbx_pkg::TICK_DIV2:  tick = div2;
      tbx_pkg::TICK_TMRA0: tick = tmra0_tick;
      tbx_pkg::TICK_TMRA1: tick = tmra1_tick;
      tbx_pkg::TICK_EVENT: tick = cnt_smp && !cnt_prev;
      default:             tick = 1'b0;
    endcase
  end

  // power-down always wins; standby only halts without keep-running
  assign active = control_primary[tbx_pkg::ENABLE_BIT] &&
                  !sleep_powerdown &&
                  !(sleep_standby &&
                    !control_primary[tbx_pkg::KEEP_STDBY]) &&
                  !(debug_halt &&
                    !debug_halt_control[tbx_pkg::DBG_KEEP_BIT]);

  // ---------------------------------------------------------------
  // counter and mode actions
  // ---------------------------------------------------------------
  always_comb begin
    next_cnt  = counter_value;
    next_compare_capture_value = compare_capture_value;
    next_run  = running;
    snap_set  = 1'b0;
    wrap_set  = 1'b0;
    trig      = async_on ? async_e : (edge_inv ? (pos_e || neg_e) : pos_e);
    if (active) begin
      if (tick && running) begin
        next_cnt = counter_value + 16'h0001;
        wrap_set = counter_value == tbx_pkg::COUNT_MAX;
      end
      case (mode)
        tbx_pkg::MODE_PERIODIC: begin
          next_run = 1'b1;
          if (tick && running &&
              counter_value == compare_capture_value) begin
            next_cnt = tbx_pkg::RESET_WORD;
            snap_set = 1'b1;
          end
        end
        tbx_pkg::MODE_TIMEOUT: begin
          if (snap_go && sel_e) begin
            next_run = 1'b1;
            next_cnt = tbx_pkg::RESET_WORD;
          end else if (snap_go && oth_e) begin
            next_run = 1'b0;
          end
          if (tick && running &&
              counter_value == compare_capture_value) begin
            snap_set = 1'b1;
          end
        end
        tbx_pkg::MODE_CAPTURE: begin
          next_run = 1'b1;
          if (snap_go && sel_e) begin
            next_compare_capture_value = counter_value;
            snap_set  = 1'b1;
          end
        end
        tbx_pkg::MODE_FREQ, tbx_pkg::MODE_FREQ_PW: begin
          next_run = 1'b1;
          if (snap_go && sel_e) begin
            next_compare_capture_value = counter_value;
            next_cnt  = tbx_pkg::RESET_WORD;
            snap_set  = 1'b1;
          end
        end
        tbx_pkg::MODE_PWIDTH: begin
          next_run = 1'b1;
          if (snap_go && sel_e) begin
            next_cnt = tbx_pkg::RESET_WORD;
          end else if (snap_go && oth_e) begin
            next_compare_capture_value = counter_value;
            snap_set  = 1'b1;
          end
        end
        tbx_pkg::MODE_SINGLE: begin
          if (!running && snap_go && trig) begin
            next_run = 1'b1;
            next_cnt = tbx_pkg::RESET_WORD;
          end else if (tick && running &&
                       counter_value == compare_capture_value) begin
            next_run = 1'b0;
            snap_set = 1'b1;
          end
        end
        tbx_pkg::MODE_PWM8: begin
          next_run = 1'b1;
          if (tick && running &&
              counter_value[7:0] == compare_capture_value[7:0]) begin
            next_cnt = tbx_pkg::RESET_WORD;
            snap_set = 1'b1;
          end
        end
        default: next_run = 1'b0;
      endcase
    end else if (!control_primary[tbx_pkg::ENABLE_BIT]) begin
      next_run = 1'b0;
    end
  end

  // software writes to counter or compare override the mode action
  always_ff @(posedge clk) begin
    if (rst) begin
      counter_value         <= tbx_pkg::RESET_WORD;
      compare_capture_value <= tbx_pkg::RESET_WORD;
      running               <= 1'b0;
    end else if (ce) begin
      counter_value <= cnt_wr ? merge16(counter_value, s_axi_wdata,
                                        s_axi_wstrb) : next_cnt;
      compare_capture_value <= compare_capture_value_wr ?
        merge16(compare_capture_value, s_axi_wdata, s_axi_wstrb) :
        next_compare_capture_value;
      running <= next_run;
    end
  end

  // ---------------------------------------------------------------
  // flags, events, request
  // ---------------------------------------------------------------
  // a set in the same cycle as a clear wins, so no event is lost
  always_ff @(posedge clk) begin
    if (rst) begin
      pending_flags <= 2'h0;
    end else if (ce) begin
      pending_flags[tbx_pkg::SNAP_FLAG] <= snap_set ||
        (pending_flags[tbx_pkg::SNAP_FLAG] &&
         !flag_clr[tbx_pkg::SNAP_FLAG]);
      pending_flags[tbx_pkg::WRAP_FLAG] <= wrap_set ||
        (pending_flags[tbx_pkg::WRAP_FLAG] &&
         !flag_clr[tbx_pkg::WRAP_FLAG]);
    end
  end

  // event pulses share the flag-set terms
  always_ff @(posedge clk) begin
    if (rst) begin
      snapshot_event <= 1'b0;
      wrap_event     <= 1'b0;
    end else if (ce) begin
      snapshot_event <= snap_set;
      wrap_event     <= wrap_set;
    end
  end

  // request follows flags one cycle later, out of a flop
  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(pending_flags & source_enables[1:0] &
               tbx_pkg::FLAG_MASK);
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_wrap_cause;
    ce && active && tick && running && !cnt_wr &&
    counter_value == tbx_pkg::COUNT_MAX && mode == tbx_pkg::MODE_CAPTURE;
  endsequence
  sequence s_wrap_seen;
    counter_value == tbx_pkg::RESET_WORD && pending_flags[1] && wrap_event;
  endsequence

  property p_wrap;
    s_wrap_cause |=> s_wrap_seen;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap missed");

  property p_snap_pulse;
    snapshot_event |-> pending_flags[0] && $past(ce);
  endproperty
  a_snap_pulse: assert property (p_snap_pulse)
    else $error("snapshot pulse without flag");

  property p_irq;
    ce |=> irq == $past(|(pending_flags & source_enables[1:0]));
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_clear;
    (ce && flag_clr[0] && !snap_set) |=> !pending_flags[0];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  property p_hold;
    (ce && pending_flags[1] && !flag_clr[1]) |=> pending_flags[1];
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost");

  property p_pdown;
    (ce && sleep_powerdown && !cnt_wr) |=> $stable(counter_value);
  endproperty
  a_pdown: assert property (p_pdown) else $error("ran in power-down");

  property p_stdby;
    (ce && sleep_standby && !cnt_wr &&
     !control_primary[tbx_pkg::KEEP_STDBY]) |=> $stable(counter_value);
  endproperty
  a_stdby: assert property (p_stdby) else $error("ran in standby");

  property p_snap_off;
    (ce && !snap_go && mode == tbx_pkg::MODE_CAPTURE && !compare_capture_value_wr)
      |=> $stable(compare_capture_value) && !snapshot_event;
  endproperty
  a_snap_off: assert property (p_snap_off)
    else $error("disabled snapshot acted");

endmodule

/* File: verification/tbx_evt_src.sv */
`timescale 1ns/1ps
// --------------------
// event routing model
// --------------------
module tbx_evt_src (
  // clock and commands from the bench
  input  wire logic clk,
  input  wire logic go_snap,
  input  wire logic go_cnt,
  input  wire logic go_short,
  // event levels towards the timer
  output logic      snapshot_evt_in,
  output logic      count_evt_in
);
  logic [1:0] snap_left = 2'h0;
  logic [1:0] cnt_left  = 2'h0;
  logic       glitch    = 1'b0;

  // sub-cycle pulse between two edges: only an unsynchronised catch sees it
  always @(posedge clk) begin
    if (go_short) begin
      #1 glitch = 1'b1;
      #2 glitch = 1'b0;
    end
  end

  // hold each event three clocks, so a level-sensitive timer over-acts
  always @(posedge clk) begin
    snap_left <= go_snap ? 2'h3 : snap_left - {1'b0, snap_left != 2'h0};
    cnt_left  <= go_cnt ? 2'h3 : cnt_left - {1'b0, cnt_left != 2'h0};
  end

  // clock-aligned levels plus the sub-cycle glitch on the snapshot line, idle low between deliveries
  assign snapshot_evt_in = snap_left != 2'h0 || glitch;
  assign count_evt_in    = cnt_left != 2'h0;
endmodule

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  // --------------------
  // pins and bookkeeping
  // --------------------
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        snapshot_evt_in, count_evt_in, go_snap = 1'b0;
  logic        go_cnt = 1'b0, tmra0_tick = 1'b0, tmra1_tick = 1'b0;
  logic        go_short = 1'b0;
  logic        sleep_standby = 1'b0, sleep_powerdown = 1'b0;
  logic        debug_halt = 1'b0, snapshot_event, wrap_event, irq;
  int          miscompares = 0, num_checks = 0, n_snap = 0, n_wrap = 0;
  logic [7:0]  prim [8] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h0f, 8'h01,
                            8'h41, 8'h41};
  logic [1:0]  slp [8]  = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
  logic        mv [8]   = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};

  always #4 clk = ~clk;

  tbx_timer_evt DUT (.clk, .rst, .ce, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .snapshot_evt_in,
    .count_evt_in, .tmra0_tick, .tmra1_tick, .sleep_standby,
    .sleep_powerdown, .debug_halt, .snapshot_event, .wrap_event, .irq);

  tbx_evt_src EVT (.clk, .go_snap, .go_cnt, .go_short, .snapshot_evt_in,
    .count_evt_in);

  // count high cycles: a stretched pulse shows up as extra counts
  always @(posedge clk) begin
    if (snapshot_event === 1'b1) n_snap <= n_snap + 1;
    if (wrap_event === 1'b1) n_wrap <= n_wrap + 1;
  end

  // --------------------
  // bus and check tasks
  // --------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // extra edge at the end lets flag and irq updates land
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do @(posedge clk); while ((s_axi_awready & s_axi_wready) !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [5:0] a);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready  <= 1'b0;
  endtask

  // 0: count event, 1: snapshot event, 2: sub-cycle snapshot glitch
  task automatic fire(input logic [1:0] s);
    @(posedge clk);
    go_cnt   <= s == 2'h0;
    go_snap  <= s == 2'h1;
    go_short <= s == 2'h2;
    @(posedge clk);
    go_snap  <= 1'b0;
    go_cnt   <= 1'b0;
    go_short <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic test_done;
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // --------------------
  // test sequence
  // --------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(6'h14);
    chk(v, 32'h0);
    rd(6'h08);
    chk({30'h0, r}, {30'h0, tbx_pkg::RESP_SLVERR});
    wr(6'h08, 32'h1);
    chk({30'h0, r}, {30'h0, tbx_pkg::RESP_SLVERR});
    wr(6'h04, {29'h0, tbx_pkg::MODE_CAPTURE});
    wr(6'h14, 32'h3);
    chk({30'h0, r}, {30'h0, tbx_pkg::RESP_OKAY});
    wr(6'h28, 32'hfff0);
    wr(6'h00, 32'h1);
    repeat (30) @(posedge clk);
    wr(6'h00, 32'h0);
    chk(n_wrap, 32'h1);
    rd(6'h18);
    chk(v, 32'h2);
    chk(irq, 32'h1);
    wr(6'h14, 32'h1);
    chk(irq, 32'h0);
    wr(6'h18, 32'h1);
    rd(6'h18);
    chk(v, 32'h2);
    wr(6'h14, 32'h3);
    chk(irq, 32'h1);
    wr(6'h18, 32'h2);
    chk(irq, 32'h0);
    wr(6'h28, 32'hffff);
    wr(6'h00, 32'h0f);
    repeat (10) @(posedge clk);
    chk(n_wrap, 32'h1);
    fire(1'b0);
    chk(n_wrap, 32'h2);
    rd(6'h28);
    chk(v, 32'h0);
    wr(6'h00, 32'h05);
    wr(6'h18, 32'h3);
    fire(1'b1);
    chk(n_snap, 32'h0);
    wr(6'h10, 32'h1);
    fire(1'b1);
    chk(n_snap, 32'h1);
    rd(6'h18);
    chk(v, 32'h1);
    chk(irq, 32'h1);
    // tick sources and sleep states: does the count move
    for (int i = 0; i < 8; i++) begin
      wr(6'h00, 32'h0);
      wr(6'h28, 32'h0);
      wr(6'h00, {24'h0, prim[i]});
      {sleep_powerdown, sleep_standby} <= slp[i];
      repeat (40) @(posedge clk);
      {sleep_powerdown, sleep_standby} <= 2'h0;
      rd(6'h28);
      chk({31'h0, v > 32'd16}, {31'h0, mv[i]});
    end
    // a glitch between edges is missed by the synchronous capture path
    fire(2'h2);
    chk(n_snap, 32'h1);
    // async single-shot catches it, runs to compare 2 and raises one pulse
    wr(6'h00, 32'h0);
    wr(6'h04, 32'h46);
    wr(6'h30, 32'h2);
    wr(6'h00, 32'h1);
    fire(2'h2);
    chk(n_snap, 32'h2);
    test_done;
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done;
  end
endmodule
